/* File: design/lin_cfg_pkg.sv */
// Package: register map, field layout, reset values and types of the LIN node configuration block
`default_nettype none
package lin_cfg_pkg;
	// ==========================================================
	// Direct register selects
	localparam logic [1:0] SEL_NODE_CONFIG = 2'h0;
	localparam logic [1:0] SEL_INDEX = 2'h1;
	localparam logic [1:0] SEL_WINDOW = 2'h2;
	// ==========================================================
	// Indirect register indices
	localparam logic [7:0] IDX_LINK_COMMAND = 8'h08;
	localparam logic [7:0] IDX_LINK_STATUS = 8'h09;
	localparam logic [7:0] IDX_FRAME_LEN_CKS = 8'h0b;
	localparam logic [7:0] IDX_BAUD_DIV_LOW = 8'h0c;
	localparam logic [7:0] IDX_BAUD_SCALE = 8'h0d;
	// ==========================================================
	// Field positions
	localparam int CFG_ACTIVATE_BIT = 7;
	localparam int CFG_MASTER_BIT = 6;
	localparam int CFG_AUTO_RATE_BIT = 5;
	localparam int CMD_CLR_IRQ_BIT = 3;
	localparam int CMD_CLR_ERR_BIT = 2;
	localparam int SIZE_ENHANCED_BIT = 7;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_ERR_BIT = 2;
	localparam int STAT_IRQ_BIT = 3;
	localparam int STAT_AUTO_BIT = 5;
	localparam int STAT_MASTER_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;
	// ==========================================================
	// Reset values and limits
	localparam logic [7:0] NODE_CONFIG_RST = 8'h00;
	localparam logic [7:0] INDEX_RST = 8'h00;
	localparam logic [7:0] SCALE_RST = 8'h00;
	localparam logic [7:0] DIV_LOW_RST = 8'h00;
	localparam logic [7:0] FRAME_LEN_RST = 8'h00;
	localparam logic [8:0] DIVIDER_MIN = 9'h0c8;
	localparam logic [3:0] LEN_FROM_ID = 4'hf;
	localparam logic [3:0] LEN_MAX = 4'h8;
	localparam int SYS_CLOCK_MIN_HZ = 8000000;
	localparam int CLK_PERIOD_NS = 10;

	// Direct register access strobe bundle
	typedef struct packed {
		logic [1:0] sel;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} sfr_req_t;

	// Checksum engine states
	typedef enum logic [1:0] {
		CK_IDLE,
		CK_RUN,
		CK_FOLD
	} cks_state_t;

	// Whole state of the main module
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] idx;
		logic [7:0] scale;
		logic [7:0] div_lo;
		logic [7:0] size;
		logic err;
		logic irq;
		logic [7:0] rdata;
		logic [3:0] pre_cnt;
		logic [8:0] div_cnt;
		logic [4:0] mul_cnt;
		logic tick;
		cks_state_t st;
		logic [7:0] acc;
		logic [3:0] cnt;
		logic [3:0] len;
		logic [7:0] cks;
		logic cks_done;
		logic done_flag;
	} node_state_t;

	// Whole state of the two-entry buffer
	typedef struct packed {
		logic [1:0][7:0] mem;
		logic wp;
		logic rp;
		logic [1:0] level;
	} buf_state_t;
endpackage
`default_nettype wire

/* File: design/byte_skid_buffer.sv */
// Two-entry byte buffer with valid/ready on both sides
`default_nettype none
module byte_skid_buffer import lin_cfg_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Filling side
	input wire logic IN_VALID,
	output logic IN_READY,
	input wire logic [7:0] IN_DATA,
	// Draining side
	output logic OUT_VALID,
	input wire logic OUT_READY,
	output logic [7:0] OUT_DATA
);
	buf_state_t s_q, s_d;
	logic push, pop;

	// ==========================================================
	// Handshakes; full and empty come straight from the level
	assign IN_READY = (s_q.level != 2'h2);
	assign OUT_VALID = (s_q.level != 2'h0);
	assign OUT_DATA = s_q.mem[s_q.rp]; // Entry is a flop, so data leaves registered
	assign push = IN_VALID && IN_READY;
	assign pop = OUT_VALID && OUT_READY;

	// Next state
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = IN_DATA;
			s_d.wp = ~s_q.wp;
		end
		if (pop) begin
			s_d.rp = ~s_q.rp;
		end
		if (push && !pop) begin
			s_d.level = s_q.level + 2'h1;
		end else if (pop && !push) begin
			s_d.level = s_q.level - 2'h1;
		end
	end

	// State register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // byte_skid_buffer
`default_nettype wire

/* File: design/lin_node_config_baud.sv */
// LIN node configuration registers, bit-rate tick generator and checksum engine
// Functional notes
// - The bit rate is the clock divided by 2^(prescaler+1), by the divider and, at manual rate, by (multiplier+1).
// - Prescaler spans 0..3, multiplier 0..31 and divider 200..511.
// - Bit six of the node configuration register selects master or slave role.
// - Bit five of the node configuration register selects manual or automatic rate detection.
// - Automatic rate detection works only in slave role; a master always uses the manual rate.
// - All registers but node configuration and the index are reached through the index register and a data window.
// - Frame checksums are computed in hardware, classic or enhanced as software selects.
// - The scale register holds prescaler in bits 7:6, multiplier in 5:1 and divider bit 8 in bit 0.
// - Divider bits 7:0 live at index 0x0c behind the window.
// - Writing 0x80 to the frame length and checksum register selects the enhanced checksum.
// - Node configuration bit seven activates the interface and bit six set means master.
// - Writing 0x0c to the command register clears pending error flags and the interrupt request.
`default_nettype none
module lin_node_config_baud import lin_cfg_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Direct register port
	input wire logic [1:0] SFR_SEL,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	// Settings toward the frame engines
	output logic LINK_ENABLE,
	output logic MASTER_ROLE,
	output logic AUTO_RATE,
	output logic ENHANCED_CKS,
	output logic [3:0] FRAME_LEN,
	output logic BIT_TICK,
	// Events from the frame engines
	input wire logic ERR_EVENT,
	input wire logic IRQ_EVENT,
	output logic ERR_PENDING,
	output logic IRQ_PENDING,
	// Checksum byte stream
	input wire logic FRAME_START,
	input wire logic [7:0] FRAME_PID,
	input wire logic BYTE_VALID,
	output logic BYTE_READY,
	input wire logic [7:0] BYTE_DATA,
	output logic [7:0] CKS_VALUE,
	output logic CKS_DONE
);
	node_state_t s_q, s_d;
	sfr_req_t req;
	logic buf_valid, buf_ready;
	logic [7:0] buf_data;
	logic auto_eff, active;
	logic [1:0] presc;
	logic [4:0] mult;
	logic [8:0] divider, div_eff;
	logic [3:0] pre_top;
	logic pre_hit, div_hit, mul_hit;
	logic win_wr, win_rd;
	logic [8:0] sum;
	logic [3:0] len_dec;
	logic [7:0] status;

	// ==========================================================
	// Request bundle
	assign req = '{sel: SFR_SEL, wr: SFR_WR, rd: SFR_RD, wdata: SFR_WDATA};
	assign win_wr = req.wr && (req.sel == SEL_WINDOW);
	assign win_rd = req.rd && (req.sel == SEL_WINDOW);

	// ==========================================================
	// Byte stream buffer; the engine stalls it while idle, so only a switch-off mid-frame drops a byte
	byte_skid_buffer u_buf (
		.CLK(CLK),
		.RST_N(RST_N),
		.IN_VALID(BYTE_VALID),
		.IN_READY(BYTE_READY),
		.IN_DATA(BYTE_DATA),
		.OUT_VALID(buf_valid),
		.OUT_READY(buf_ready),
		.OUT_DATA(buf_data)
	);

	// ==========================================================
	// Decoded settings
	assign active = s_q.cfg[CFG_ACTIVATE_BIT];
	assign auto_eff = s_q.cfg[CFG_AUTO_RATE_BIT] && !s_q.cfg[CFG_MASTER_BIT];
	assign presc = s_q.scale[7:6];
	assign mult = auto_eff ? 5'h00 : s_q.scale[5:1];
	assign divider = {s_q.scale[0], s_q.div_lo};
	// Values below the floor would push the tick past the bit-rate range
	assign div_eff = (divider < DIVIDER_MIN) ? DIVIDER_MIN : divider;
	assign pre_top = 4'((5'h02 << presc) - 5'h01); // 2^(p+1) clocks per stage
	assign pre_hit = (s_q.pre_cnt == pre_top);
	assign div_hit = pre_hit && (s_q.div_cnt == div_eff - 9'h001);
	assign mul_hit = div_hit && (s_q.mul_cnt == mult);

	// Length decoded from the identifier when software asks for it
	always_comb begin
		len_dec = s_q.size[3:0];
		if (s_q.size[3:0] == LEN_FROM_ID) begin
			case (FRAME_PID[5:4])
				2'h0: len_dec = 4'h2;
				2'h1: len_dec = 4'h2;
				2'h2: len_dec = 4'h4;
				default: len_dec = 4'h8;
			endcase
		end else if (s_q.size[3:0] > LEN_MAX) begin
			len_dec = LEN_MAX;
		end
	end

	// Carry-folding add of the next byte
	assign sum = {1'b0, s_q.acc} + {1'b0, buf_data};
	assign buf_ready = (s_q.st == CK_RUN);

	// Status view of the block's own state
	always_comb begin
		status = 8'h00;
		status[STAT_DONE_BIT] = s_q.done_flag;
		status[STAT_ERR_BIT] = s_q.err;
		status[STAT_IRQ_BIT] = s_q.irq;
		status[STAT_AUTO_BIT] = auto_eff;
		status[STAT_MASTER_BIT] = s_q.cfg[CFG_MASTER_BIT];
		status[STAT_BUSY_BIT] = (s_q.st != CK_IDLE);
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.cks_done = 1'b0;

		// Direct registers
		if (req.wr && req.sel == SEL_NODE_CONFIG) begin
			s_d.cfg = req.wdata;
		end else if (req.wr && req.sel == SEL_INDEX) begin
			s_d.idx = req.wdata;
		end

		// Window writes land in the register picked by the index
		if (win_wr) begin
			if (s_q.idx == IDX_BAUD_SCALE) begin
				s_d.scale = req.wdata;
			end else if (s_q.idx == IDX_BAUD_DIV_LOW) begin
				s_d.div_lo = req.wdata;
			end else if (s_q.idx == IDX_FRAME_LEN_CKS) begin
				s_d.size = req.wdata;
			end else if (s_q.idx == IDX_LINK_COMMAND) begin
				if (req.wdata[CMD_CLR_ERR_BIT]) begin
					s_d.err = 1'b0;
					s_d.done_flag = 1'b0;
				end
				if (req.wdata[CMD_CLR_IRQ_BIT]) begin
					s_d.irq = 1'b0;
				end
			end
		end
		// Hardware events win over a clear in the same cycle
		if (ERR_EVENT) begin
			s_d.err = 1'b1;
		end
		if (IRQ_EVENT) begin
			s_d.irq = 1'b1;
		end

		// Reads through the window and directly; unmapped indices read zero
		if (req.rd) begin
			if (req.sel == SEL_NODE_CONFIG) begin
				s_d.rdata = s_q.cfg;
			end else if (req.sel == SEL_INDEX) begin
				s_d.rdata = s_q.idx;
			end else if (win_rd && s_q.idx == IDX_BAUD_SCALE) begin
				s_d.rdata = s_q.scale;
			end else if (win_rd && s_q.idx == IDX_BAUD_DIV_LOW) begin
				s_d.rdata = s_q.div_lo;
			end else if (win_rd && s_q.idx == IDX_FRAME_LEN_CKS) begin
				s_d.rdata = s_q.size;
			end else if (win_rd && s_q.idx == IDX_LINK_STATUS) begin
				s_d.rdata = status;
			end else begin
				s_d.rdata = 8'h00;
			end
		end

		// Cascaded counters; held cleared while the interface is off
		if (!active) begin
			s_d.pre_cnt = 4'h0;
			s_d.div_cnt = 9'h000;
			s_d.mul_cnt = 5'h00;
		end else begin
			s_d.pre_cnt = pre_hit ? 4'h0 : s_q.pre_cnt + 4'h1;
			if (div_hit) begin
				s_d.div_cnt = 9'h000;
				s_d.mul_cnt = mul_hit ? 5'h00 : s_q.mul_cnt + 5'h01;
			end else if (pre_hit) begin
				s_d.div_cnt = s_q.div_cnt + 9'h001;
			end
			s_d.tick = mul_hit;
		end

		// Checksum engine: classic sums data only, enhanced seeds with the identifier
		case (s_q.st)
			CK_IDLE: begin
				if (FRAME_START && active) begin
					s_d.acc = s_q.size[SIZE_ENHANCED_BIT] ? FRAME_PID : 8'h00;
					s_d.cnt = 4'h0;
					s_d.len = len_dec;
					s_d.done_flag = 1'b0;
					s_d.st = CK_RUN;
				end
			end
			CK_RUN: begin
				if (!active) begin
					s_d.st = CK_IDLE;
				end else if (buf_valid) begin
					s_d.acc = sum[7:0] + {7'h00, sum[8]};
					s_d.cnt = s_q.cnt + 4'h1;
					if (s_q.cnt + 4'h1 >= s_q.len) begin
						s_d.st = CK_FOLD;
					end
				end
			end
			CK_FOLD: begin
				s_d.cks = ~s_q.acc;
				s_d.cks_done = 1'b1;
				s_d.done_flag = 1'b1;
				s_d.st = CK_IDLE;
			end
			default: begin
				s_d.st = CK_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.cfg <= NODE_CONFIG_RST;
			s_q.idx <= INDEX_RST;
			s_q.scale <= SCALE_RST;
			s_q.div_lo <= DIV_LOW_RST;
			s_q.size <= FRAME_LEN_RST;
			s_q.st <= CK_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	assign SFR_RDATA = s_q.rdata;
	assign LINK_ENABLE = active;
	assign MASTER_ROLE = s_q.cfg[CFG_MASTER_BIT];
	assign AUTO_RATE = auto_eff;
	assign ENHANCED_CKS = s_q.size[SIZE_ENHANCED_BIT];
	assign FRAME_LEN = s_q.size[3:0];
	assign BIT_TICK = s_q.tick;
	assign ERR_PENDING = s_q.err;
	assign IRQ_PENDING = s_q.irq;
	assign CKS_VALUE = s_q.cks;
	assign CKS_DONE = s_q.cks_done;
endmodule // lin_node_config_baud
`default_nettype wire

/* File: verification/lin_node_monitor.sv */
// Assertion checker for the LIN node configuration block
`default_nettype none
module lin_node_monitor import lin_cfg_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [1:0] SFR_SEL,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	input wire logic [7:0] SFR_RDATA,
	// Settings, tick and events
	input wire logic LINK_ENABLE,
	input wire logic MASTER_ROLE,
	input wire logic AUTO_RATE,
	input wire logic BIT_TICK,
	input wire logic ERR_EVENT,
	input wire logic IRQ_EVENT,
	input wire logic ERR_PENDING,
	input wire logic IRQ_PENDING,
	// Checksum result
	input wire logic [7:0] CKS_VALUE,
	input wire logic CKS_DONE
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Properties
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire cfg_wr = SFR_WR && SFR_SEL == SEL_NODE_CONFIG;
	property p_cfg_write;
		cfg_wr |=> LINK_ENABLE == $past(SFR_WDATA[7]) && MASTER_ROLE == $past(SFR_WDATA[6]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config bits not applied");
	property p_auto_slave;
		cfg_wr |=> AUTO_RATE == ($past(SFR_WDATA[5]) && !$past(SFR_WDATA[6]));
	endproperty
	a_auto_slave: assert property (p_auto_slave) else $error("auto rate select wrong");
	property p_master_manual;
		MASTER_ROLE |-> !AUTO_RATE;
	endproperty
	a_master_manual: assert property (p_master_manual) else $error("master in auto rate");
	property p_tick_pulse;
		BIT_TICK |=> !BIT_TICK [*8];
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
	property p_tick_idle;
		!LINK_ENABLE [*2] |-> !BIT_TICK;
	endproperty
	a_tick_idle: assert property (p_tick_idle) else $error("tick while disabled");
	property p_done_pulse;
		CKS_DONE |=> !CKS_DONE;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	property p_cks_hold;
		!CKS_DONE |-> $stable(CKS_VALUE);
	endproperty
	a_cks_hold: assert property (p_cks_hold) else $error("checksum moved");
	property p_err_set;
		ERR_EVENT |=> ERR_PENDING;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error flag not set");
	property p_irq_set;
		IRQ_EVENT |=> IRQ_PENDING;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("interrupt flag not set");
	property p_err_hold;
		ERR_PENDING && !SFR_WR |=> ERR_PENDING;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag lost");
	property p_rd_hold;
		!SFR_RD |=> $stable(SFR_RDATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	// Main scenarios reached
	c_tick: cover property (BIT_TICK);
	c_done: cover property (CKS_DONE);
	c_flags: cover property (ERR_PENDING && IRQ_PENDING);
endmodule // lin_node_monitor
bind lin_node_config_baud lin_node_monitor mon_u (.CLK(CLK), .RST_N(RST_N), .SFR_SEL(SFR_SEL),
	.SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
	.LINK_ENABLE(LINK_ENABLE), .MASTER_ROLE(MASTER_ROLE), .AUTO_RATE(AUTO_RATE), .BIT_TICK(BIT_TICK),
	.ERR_EVENT(ERR_EVENT), .IRQ_EVENT(IRQ_EVENT), .ERR_PENDING(ERR_PENDING), .IRQ_PENDING(IRQ_PENDING),
	.CKS_VALUE(CKS_VALUE), .CKS_DONE(CKS_DONE));
`default_nettype wire

/* File: verification/lin_far_node.sv */
// Far-side frame engine model: byte stream, frame start and events
`default_nettype none
module lin_far_node (
	// Clock
	input wire logic CLK,
	// Byte stream
	input wire logic BYTE_READY,
	output logic BYTE_VALID,
	output logic [7:0] BYTE_DATA,
	output logic FRAME_START,
	output logic [7:0] FRAME_PID,
	// Events
	output logic ERR_EVENT,
	output logic IRQ_EVENT
);
	timeunit 1ns;
	timeprecision 1ps;
	// Set when a byte was never taken; the bench counts it as a mismatch
	logic stuck = 1'b0;
	// Idle levels at time zero
	initial begin
		{BYTE_VALID, FRAME_START, ERR_EVENT, IRQ_EVENT} = 4'h0;
		{BYTE_DATA, FRAME_PID} = 16'h5aa5;
	end
	// Offer one byte, maybe late, and hold it until taken
	// At least one idle edge first, so valid never drops and rises in one time step
	task automatic push(input logic [7:0] b);
		int n = 0;
		repeat (1 + $urandom % 3) @(posedge CLK);
		BYTE_VALID <= 1'b1;
		BYTE_DATA <= b;
		do begin
			@(posedge CLK);
			n++;
		end while (!BYTE_READY && n < 300);
		if (!BYTE_READY)
			stuck = 1'b1;
		BYTE_VALID <= 1'b0;
		BYTE_DATA <= ~b; // Released: no stale byte left on the lines
	endtask
	// Frame start with identifier, the seed of the enhanced sum
	task automatic start(input logic [7:0] pid);
		@(posedge CLK);
		FRAME_START <= 1'b1;
		FRAME_PID <= pid;
		@(posedge CLK);
		FRAME_START <= 1'b0;
		FRAME_PID <= ~pid;
	endtask
	// One-cycle event pulses
	task automatic pulse(input logic e, input logic i);
		@(posedge CLK);
		{ERR_EVENT, IRQ_EVENT} <= {e, i};
		@(posedge CLK);
		{ERR_EVENT, IRQ_EVENT} <= 2'h0;
	endtask
endmodule // lin_far_node
`default_nettype wire

/* File: verification/lin_node_config_baud_test.sv */
// Self-checking testbench for the LIN node configuration block
`default_nettype none
module lin_node_config_baud_test import lin_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0, RST_N = 1'b0, SFR_WR = 1'b0, SFR_RD = 1'b0;
	logic [1:0] SFR_SEL = 2'h0;
	logic [7:0] SFR_WDATA = 8'h00, SFR_RDATA, FRAME_PID, BYTE_DATA, CKS_VALUE, sc, s, pid, sz;
	logic LINK_ENABLE, MASTER_ROLE, AUTO_RATE, ENHANCED_CKS, BIT_TICK, ERR_EVENT, IRQ_EVENT;
	logic ERR_PENDING, IRQ_PENDING, FRAME_START, BYTE_VALID, BYTE_READY, CKS_DONE, auto, rd_d = 1'b0, have = 1'b0;
	logic [3:0] FRAME_LEN;
	logic [8:0] t;
	logic [7:0] rq[$], cq[$], b[3];
	int gq[$];
	int n_mismatch = 0, comparisons = 0, gap = 0;
	// Auto slave, master with auto bit set, divider floor, random
	logic [7:0] cfgs[4] = '{8'ha0, 8'he0, 8'h80, 8'h80};
	logic [1:0] ps[4] = '{2'h3, 2'h3, 2'h0, 2'h0};
	logic [4:0] ms[4] = '{5'h07, 5'h01, 5'h00, 5'h00};
	logic [8:0] divs[4] = '{9'h138, 9'h145, 9'h064, 9'h0c8};
	// ==========================================================
	// Clock, design and far side
	always #5 CLK = ~CLK; // 100 MHz, above the minimum
	lin_node_config_baud dut_u (.CLK(CLK), .RST_N(RST_N), .SFR_SEL(SFR_SEL), .SFR_WR(SFR_WR),
		.SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .LINK_ENABLE(LINK_ENABLE),
		.MASTER_ROLE(MASTER_ROLE), .AUTO_RATE(AUTO_RATE), .ENHANCED_CKS(ENHANCED_CKS), .FRAME_LEN(FRAME_LEN),
		.BIT_TICK(BIT_TICK), .ERR_EVENT(ERR_EVENT), .IRQ_EVENT(IRQ_EVENT), .ERR_PENDING(ERR_PENDING),
		.IRQ_PENDING(IRQ_PENDING), .FRAME_START(FRAME_START), .FRAME_PID(FRAME_PID), .BYTE_VALID(BYTE_VALID),
		.BYTE_READY(BYTE_READY), .BYTE_DATA(BYTE_DATA), .CKS_VALUE(CKS_VALUE), .CKS_DONE(CKS_DONE));
	lin_far_node model_u (.CLK(CLK), .BYTE_READY(BYTE_READY), .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA),
		.FRAME_START(FRAME_START), .FRAME_PID(FRAME_PID), .ERR_EVENT(ERR_EVENT), .IRQ_EVENT(IRQ_EVENT));
	// ==========================================================
	// Compare, verdict and bus tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_gap(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (rq.size() || gq.size() || cq.size() || model_u.stuck)
			n_mismatch++;
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [1:0] sl, input logic [7:0] d);
		@(posedge CLK);
		SFR_SEL <= sl;
		SFR_WDATA <= d;
		SFR_WR <= 1'b1;
		@(posedge CLK);
		SFR_WR <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] sl, input logic [7:0] e);
		@(posedge CLK);
		SFR_SEL <= sl;
		SFR_RD <= 1'b1;
		rq.push_back(e);
		@(posedge CLK);
		SFR_RD <= 1'b0;
	endtask
	task automatic iw(input logic [7:0] i, input logic [7:0] d);
		wr(SEL_INDEX, i);
		wr(SEL_WINDOW, d);
	endtask
	task automatic ir(input logic [7:0] i, input logic [7:0] e);
		wr(SEL_INDEX, i);
		rd(SEL_WINDOW, e);
	endtask
	// Bounded wait for pending gap and checksum notes; a hang ends the run
	task automatic drain(input int lim);
		int n = 0;
		while ((gq.size() || cq.size()) && n < lim) begin
			@(posedge CLK);
			n++;
		end
		if (gq.size() || cq.size())
			report_and_stop();
	endtask
	// Result watcher: oldest note against each result that shows
	always @(posedge CLK) begin
		if (rd_d)
			chk(SFR_RDATA, rq.size() ? rq.pop_front() : 8'hxx);
		rd_d = SFR_RD;
		if (CKS_DONE)
			chk(CKS_VALUE, cq.size() ? cq.pop_front() : 8'hxx);
		if (BIT_TICK) begin
			if (have && gq.size())
				chk_gap(gap, gq.pop_front());
			have = 1'b1;
			gap = 0;
		end
		gap++;
		if (!LINK_ENABLE)
			have = 1'b0;
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h4ba6));
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		rd(SEL_NODE_CONFIG, NODE_CONFIG_RST);
		ir(IDX_BAUD_SCALE, SCALE_RST);
		rd(2'h3, 8'h00);
		iw(8'h30, 8'h55);
		ir(8'h30, 8'h00);
		ir(IDX_LINK_COMMAND, 8'h00);
		ps[3] = 2'($urandom % 2);
		ms[3] = 5'($urandom % 4);
		divs[3] = 9'(200 + $urandom % 312);
		// Settings change only while the interface is off
		for (int k = 0; k < 4; k++) begin
			sc = {ps[k], ms[k], divs[k][8]};
			wr(SEL_NODE_CONFIG, 8'h00);
			iw(IDX_BAUD_SCALE, sc);
			iw(IDX_BAUD_DIV_LOW, divs[k][7:0]);
			ir(IDX_BAUD_SCALE, sc);
			ir(IDX_BAUD_DIV_LOW, divs[k][7:0]);
			wr(SEL_NODE_CONFIG, cfgs[k]);
			auto = cfgs[k][5] && !cfgs[k][6];
			ir(IDX_LINK_STATUS, {1'b0, cfgs[k][6], auto, 5'h00});
			gq.push_back((2 << ps[k]) * (divs[k] < 200 ? 200 : divs[k]) * (auto ? 1 : ms[k] + 1));
			drain(40000);
		end
		wr(SEL_NODE_CONFIG, 8'h80);
		// Classic, enhanced, then length from the identifier; two bytes parked before the start
		for (int e = 0; e < 3; e++) begin
			sz = (e == 2) ? 8'h8f : {e[0], 7'h03};
			iw(IDX_FRAME_LEN_CKS, sz);
			@(posedge CLK);
			chk({ENHANCED_CKS, 3'h0, FRAME_LEN}, sz);
			// Identifier bits 5:4 kept at 0 or 1, so a 0xf length means two bytes
			pid = 8'($urandom) & 8'hdf;
			s = sz[7] ? pid : 8'h00;
			for (int i = 0; i < 3 - e / 2; i++) begin
				b[i] = 8'($urandom);
				t = s + b[i];
				s = t[7:0] + t[8];
			end
			cq.push_back(~s);
			model_u.push(b[0]);
			model_u.push(b[1]);
			@(posedge CLK);
			chk({7'h00, BYTE_READY}, 8'h00);
			model_u.start(pid);
			if (e < 2)
				model_u.push(b[2]);
			drain(300);
		end
		model_u.pulse(1'b1, 1'b1);
		ir(IDX_LINK_STATUS, 8'h0d);
		iw(IDX_LINK_COMMAND, 8'h08);
		ir(IDX_LINK_STATUS, 8'h05);
		iw(IDX_LINK_COMMAND, 8'h0c);
		ir(IDX_LINK_STATUS, 8'h00);
		repeat (2) @(posedge CLK);
		report_and_stop();
	end
endmodule // lin_node_config_baud_test
`default_nettype wire
